// >>> board_model.sv
// Board side: open-drain reset source and pulled-up interrupt line
`timescale 1ns/100ps
module board_model (
	// Clock and stimulus
	input  wire logic core_clk_i,
	input  wire logic reset_pulse_i,
	input  wire logic nmi_low_i,
	input  wire logic pin_oe_i,
	// Pins
	output logic      reset_pin_o,
	output logic      nmi_pin_o
);
	logic [1:0] low_cnt = 2'h0;
	// Three cycles: 100 ns plus two clocks
	always @(posedge core_clk_i)
		low_cnt <= reset_pulse_i ? 2'h3 : low_cnt - 2'(low_cnt != 2'h0);
	// Wired low with pull-up, so the device's own drive shows too
	assign reset_pin_o = !(pin_oe_i || low_cnt != 2'h0);
	assign nmi_pin_o = !nmi_low_i;
endmodule

// >>> reset_nmi_powerdown_control.sv
// Reset filter, reset indication, trap on interrupt pin edge and power-down gating
`timescale 1ns/100ps
module reset_nmi_powerdown_control (
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_b_i,
	// Board pins
	input  wire logic                 reset_input_pin_i,
	input  wire logic                 nmi_pin_i,
	// Requests from the core
	input  wire rst_nmi_pkg::cpu_req_t cpu_req_i,
	// Pin drivers
	output logic                      reset_input_pin_o,
	output logic                      reset_input_pin_oe_o,
	output logic                      reset_indication_output_o,
	// To the core
	output logic                      core_reset_o,
	output logic                      nmi_trap_o,
	output logic                      power_down_o,
	output logic                      power_down_ignored_o,
	output logic                      bidir_reset_enable_bit_o
);

	rst_nmi_pkg::state_t st;
	rst_nmi_pkg::state_t next_st;

	logic pin_low_filtered;
	logic any_reset;

	// Values after block reset; one field a line so a new field cannot be left out
	function automatic rst_nmi_pkg::state_t reset_state();
		rst_nmi_pkg::state_t s;
		s.phase                  = rst_nmi_pkg::ST_RESET;
		s.seq_cnt                = 8'h00;
		s.filt_cnt               = 4'h0;
		s.nmi_sync1              = rst_nmi_pkg::PIN_HIGH;
		s.nmi_sync2              = rst_nmi_pkg::PIN_HIGH;
		s.nmi_prev               = rst_nmi_pkg::PIN_HIGH;
		s.nmi_trap               = 1'b0;
		s.bidir_reset_enable_bit = rst_nmi_pkg::BIDIR_RESET_VAL;
		s.reset_indication       = 1'b0;
		s.pin_drive_low          = 1'b0;
		s.core_reset             = 1'b1;
		s.power_down             = 1'b0;
		s.pd_ignored             = 1'b0;
		return s;
	endfunction

	// Consecutive low samples of the reset pin, saturating at the filter length.
	// Held at zero while we drive the pin: our own drive reads back low and would
	// otherwise restart the sequence on the cycle the drive ends.
	function automatic logic [3:0] filter_next(
		input logic [3:0] cnt,
		input logic       pin,
		input logic       driving
	);
		logic [3:0] result;
		result = cnt;
		if (pin || driving)
		begin
			result = 4'h0;
		end
		else if (cnt != rst_nmi_pkg::FILTER_LEN)
		begin
			result = cnt + 4'h1;
		end
		return result;
	endfunction

	// Pin, software and watchdog resets all restart the same sequence
	function automatic logic reset_request(
		input logic                  pin_low,
		input rst_nmi_pkg::cpu_req_t req
	);
		return pin_low || req.sw_reset || req.watchdog_reset;
	endfunction

	// Drive stays on across back-to-back resets once it has started
	function automatic logic drive_next(input logic enable, input logic driving);
		return enable || driving;
	endfunction

	// True once the internal reset sequence has run its full length
	function automatic logic seq_done(input logic [7:0] cnt);
		return cnt == rst_nmi_pkg::INT_RESET_LEN;
	endfunction

	// High to low on the synchronised stages; the raw pin is never looked at
	function automatic logic falling_edge(input logic prev, input logic cur);
		return prev && !cur;
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.nmi_trap = 1'b0;
		next_st.pd_ignored = 1'b0;

		// Shorter glitches never reach a sample at this clock rate
		next_st.filt_cnt = filter_next(st.filt_cnt, reset_input_pin_i, st.pin_drive_low);
		// Our own drive also reads back low; ignore it so the sequence can end
		pin_low_filtered = (st.filt_cnt == rst_nmi_pkg::FILTER_LEN) && !st.pin_drive_low;

		any_reset = reset_request(pin_low_filtered, cpu_req_i);

		// Synchroniser: first stage feeds only the second
		next_st.nmi_sync1 = nmi_pin_i;
		next_st.nmi_sync2 = st.nmi_sync1;
		next_st.nmi_prev  = st.nmi_sync2;

		if (any_reset)
		begin
			next_st.phase = rst_nmi_pkg::ST_RESET;
			next_st.seq_cnt = 8'h00;
			next_st.core_reset = 1'b1;
			next_st.reset_indication = 1'b0;
			next_st.power_down = 1'b0;
			next_st.bidir_reset_enable_bit = rst_nmi_pkg::BIDIR_RESET_VAL;
			// Enable still set when the reset hits keeps the drive for this sequence
			next_st.pin_drive_low = drive_next(st.bidir_reset_enable_bit, st.pin_drive_low);
		end
		else
		begin
			case (st.phase)
				rst_nmi_pkg::ST_RESET:
				begin
					// Sequence runs full length even after a short pin pulse
					if (seq_done(st.seq_cnt))
					begin
						next_st.phase = rst_nmi_pkg::ST_INIT;
						next_st.core_reset = 1'b0;
						next_st.pin_drive_low = 1'b0;
					end
					else
					begin
						next_st.seq_cnt = st.seq_cnt + 8'h01;
					end
				end
				rst_nmi_pkg::ST_INIT:
				begin
					if (cpu_req_i.bidir_reset_enable_wr)
					begin
						next_st.bidir_reset_enable_bit = cpu_req_i.bidir_reset_enable_val;
					end
					if (cpu_req_i.end_of_init_instruction)
					begin
						next_st.phase = rst_nmi_pkg::ST_RUN;
						next_st.reset_indication = 1'b1;
					end
				end
				rst_nmi_pkg::ST_RUN:
				begin
					// Writes to the enable are ignored here, the bit is locked
					if (cpu_req_i.power_down_instruction)
					begin
						if (!st.nmi_sync2)
						begin
							next_st.phase = rst_nmi_pkg::ST_POWER_DOWN;
							next_st.power_down = 1'b1;
						end
						else
						begin
							next_st.pd_ignored = 1'b1;
						end
					end
				end
				rst_nmi_pkg::ST_POWER_DOWN:
				begin
					// Only a reset leaves power-down
					next_st.power_down = 1'b1;
				end
				default:
				begin
					// Unreachable; fall back to a fresh sequence rather than hang
					next_st.phase = rst_nmi_pkg::ST_RESET;
					next_st.seq_cnt = 8'h00;
					next_st.core_reset = 1'b1;
					next_st.reset_indication = 1'b0;
				end
			endcase
			// Edge taken from synchronised stages only; trap not raised in reset
			if (falling_edge(st.nmi_prev, st.nmi_sync2) && st.phase != rst_nmi_pkg::ST_RESET)
			begin
				next_st.nmi_trap = 1'b1;
			end
		end
	end

	// Block reset is taken as synchronous to the core clock
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			st <= reset_state();
		end
		else
		begin
			st <= next_st;
		end
	end

	// Open drain: the data is always low, the enable alone decides
	assign reset_input_pin_o         = 1'b0;
	assign reset_input_pin_oe_o      = st.pin_drive_low;
	assign reset_indication_output_o = st.reset_indication;
	assign core_reset_o              = st.core_reset;
	assign nmi_trap_o                = st.nmi_trap;
	assign power_down_o              = st.power_down;
	assign power_down_ignored_o      = st.pd_ignored;
	assign bidir_reset_enable_bit_o  = st.bidir_reset_enable_bit;

endmodule

// >>> reset_nmi_powerdown_control_tb.sv
// Self-checking bench for the reset and interrupt front end
`timescale 1ns/100ps
module reset_nmi_powerdown_control_tb;
	logic clk = 0, rst_b = 0, pulse = 0, nmi_low = 0;
	rst_nmi_pkg::cpu_req_t req = '0;
	logic pin, nmi, oe, ind, cres, trap, pd, pdi, bd, pdat;
	int fail_count = 0, checked = 0, cyc = 0, traps = 0, n;
	logic [15:0] lf = 16'h2E2D;
	always #50 clk = ~clk;
	reset_nmi_powerdown_control reset_nmi_powerdown_control_i (.core_clk_i(clk),
		.rst_b_i(rst_b), .reset_input_pin_i(pin), .nmi_pin_i(nmi), .cpu_req_i(req),
		.reset_input_pin_o(pdat), .reset_input_pin_oe_o(oe), .reset_indication_output_o(ind),
		.core_reset_o(cres), .nmi_trap_o(trap), .power_down_o(pd),
		.power_down_ignored_o(pdi), .bidir_reset_enable_bit_o(bd));
	board_model board_model_i (.core_clk_i(clk), .reset_pulse_i(pulse), .nmi_low_i(nmi_low),
		.pin_oe_i(oe), .reset_pin_o(pin), .nmi_pin_o(nmi));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		traps <= traps + 32'(trap === 1'b1);
		cyc <= cyc + 1;
		// Whole run needs well under a thousand cycles
		if (cyc == 3000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cmd(input rst_nmi_pkg::cpu_req_t r);
		@(posedge clk) req <= r;
		@(posedge clk) req <= '0;
		#1;
	endtask
	task automatic wait_run(output int k);
		k = 0;
		while (cres !== 1'b0 && k < 200)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wait_run(n);
		chk(8'(n >= 64 && n <= 67), 8'h01);
		chk(ind, 8'h00);
		cmd(6'h03);
		cmd(6'h08);
		chk({bd, ind}, 8'h03);
		cmd(6'h02);
		chk(bd, 8'h01);
		for (int i = 0; i < 20; i++)
		begin
			lf = lfsr(lf);
			@(posedge clk) nmi_low <= 1'b1;
			repeat (lf[1:0]) @(posedge clk);
			@(posedge clk) nmi_low <= 1'b0;
			repeat (3'(lf[3:2]) + 3'h1) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		#1;
		chk(8'(traps), 8'h14);
		cmd(6'h04);
		chk({pd, pdi}, 8'h01);
		@(posedge clk) nmi_low <= 1'b1;
		repeat (5) @(posedge clk);
		cmd(6'h04);
		chk(pd, 8'h01);
		@(posedge clk) pulse <= 1'b1;
		@(posedge clk) pulse <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk({pdat, cres, oe, ind, pd}, 8'h0C);
		wait_run(n);
		chk({oe, bd}, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			cmd(6'h03);
			cmd(6'h08);
			chk({bd, ind}, 8'h03);
			cmd(i ? 6'h10 : 6'h20);
			@(posedge clk);
			#1;
			chk({cres, oe, ind}, 8'h06);
			wait_run(n);
			chk({oe, bd}, 8'h00);
		end
		tally_and_finish();
	end
endmodule

// >>> rst_nmi_pkg.sv
// Package with constants and carrier types for the reset and interrupt front end
package rst_nmi_pkg;

	// Clock rate and timing
	localparam int CLK_PERIOD_NS        = 100;
	localparam int FILTER_REJECT_NS     = 10;
	localparam int FILTER_PASS_NS       = 100;
	// Longest rejected glitch rounds down, at least one cycle
	localparam int FILTER_REJECT_CYC    = (FILTER_REJECT_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(FILTER_REJECT_NS / CLK_PERIOD_NS);
	// Passed pulse length rounds up
	localparam int FILTER_PASS_CYC      = (FILTER_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Filter length: a low must be seen this many consecutive cycles
	localparam logic [3:0] FILTER_LEN   = 4'(FILTER_PASS_CYC);
	// Length of the internal reset sequence in cycles
	localparam logic [7:0] INT_RESET_LEN = 8'h40;

	// Values after reset
	localparam logic BIDIR_RESET_VAL    = 1'b0;
	localparam logic PIN_HIGH           = 1'b1;

	typedef enum logic [1:0] {
		ST_RESET,
		ST_INIT,
		ST_RUN,
		ST_POWER_DOWN
	} phase_t;

	// Requests from the CPU core
	typedef struct packed {
		logic sw_reset;
		logic watchdog_reset;
		logic end_of_init_instruction;
		logic power_down_instruction;
		logic bidir_reset_enable_wr;
		logic bidir_reset_enable_val;
	} cpu_req_t;

	// State of the whole block
	typedef struct packed {
		phase_t     phase;
		logic [7:0] seq_cnt;
		logic [3:0] filt_cnt;
		logic       nmi_sync1;
		logic       nmi_sync2;
		logic       nmi_prev;
		logic       nmi_trap;
		logic       bidir_reset_enable_bit;
		logic       reset_indication;
		logic       pin_drive_low;
		logic       core_reset;
		logic       power_down;
		logic       pd_ignored;
	} state_t;

endpackage

// >>> rst_nmi_sva.sv
// Port assertions for the reset and interrupt front end
`timescale 1ns/100ps
module rst_nmi_sva (
	// Clock, reset, inputs
	input wire logic                  core_clk_i,
	input wire logic                  rst_b_i,
	input wire logic                  reset_input_pin_i,
	input wire logic                  nmi_pin_i,
	input wire rst_nmi_pkg::cpu_req_t cpu_req_i,
	// Outputs
	input wire logic                  reset_input_pin_oe_o,
	input wire logic                  reset_indication_output_o,
	input wire logic                  core_reset_o,
	input wire logic                  nmi_trap_o,
	input wire logic                  power_down_o,
	input wire logic                  power_down_ignored_o,
	input wire logic                  bidir_reset_enable_bit_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence pd_req;
		cpu_req_i.power_down_instruction && reset_indication_output_o && !core_reset_o && !power_down_o;
	endsequence
	pin_reset_a: assert property (!reset_input_pin_i && !reset_input_pin_oe_o |-> ##[1:2] core_reset_o)
		else $error("pin low without reset");
	oe_in_reset_a: assert property (reset_input_pin_oe_o |-> core_reset_o)
		else $error("pin driven outside reset");
	oe_stretch_a: assert property (reset_input_pin_oe_o && core_reset_o |=> reset_input_pin_oe_o || !core_reset_o)
		else $error("pin drive cut short");
	ind_low_a: assert property (core_reset_o |-> !reset_indication_output_o)
		else $error("indication high in reset");
	ind_release_a: assert property ($rose(reset_indication_output_o) |-> $past(cpu_req_i.end_of_init_instruction))
		else $error("indication released early");
	trap_after_fall_a: assert property ($fell(nmi_pin_i) && !core_reset_o |-> ##[1:4] (nmi_trap_o || core_reset_o))
		else $error("no trap after fall");
	trap_single_a: assert property (nmi_trap_o |=> !nmi_trap_o)
		else $error("trap longer than one cycle");
	pd_enter_a: assert property ((!nmi_pin_i)[*4] ##0 pd_req |=> power_down_o)
		else $error("power-down not entered");
	pd_refuse_a: assert property (nmi_pin_i[*4] ##0 pd_req |=> power_down_ignored_o && !power_down_o)
		else $error("power-down not refused");
	enable_lock_a: assert property (reset_indication_output_o && $past(reset_indication_output_o) |-> $stable(bidir_reset_enable_bit_o))
		else $error("enable bit changed after init");
endmodule
bind reset_nmi_powerdown_control rst_nmi_sva rst_nmi_sva_i (.*);
